// *** inc/host_port_pkg.sv ***
// constants and types for the printer host receive and address decode block
// assumes a single 20 MHz clock domain
package host_port_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned BAUD = 9600;
    localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;
    localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
    localparam int unsigned ACK_NS = 5000;
    localparam int unsigned CLK_NS = 50;
    localparam int unsigned ACK_CYCLES = (ACK_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned BUF_AW = 6;
    localparam int unsigned BUF_DEPTH = 64;
    localparam logic [BUF_AW:0] NEAR_EMPTY_LEVEL = 7'h10;
    localparam logic [7:0] CHAR_RESUME = 8'h11;
    localparam logic [7:0] CHAR_PAUSE = 8'h13;
    localparam logic [23:0] IO_ONCHIP_END = 24'h0000BF;
    localparam logic [23:0] IO_EXT_END = 24'h0000FF;
    localparam logic [23:0] WORK_RAM_END = 24'h5FFFFF;
    localparam logic [23:0] PROG_END = 24'hDFFFFF;
    localparam logic [23:0] EXT_REGION_END = 24'hEFFFFF;
    localparam logic [1:0] PROTO_NONE = 2'h0;
    localparam logic [1:0] PROTO_SOFT = 2'h1;
    localparam logic [1:0] PROTO_DTR = 2'h2;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_IO_ONCHIP,
        SEL_IO_EXT,
        SEL_WORK_RAM,
        SEL_PROG_ROM,
        SEL_EXT_RAM,
        SEL_RX_BUF_RAM
    } mem_sel_t;

    typedef struct packed {
        logic valid;
        logic to_buffer;
        logic [7:0] data;
    } rx_byte_t;
endpackage : host_port_pkg

// *** rtl/rx_byte_buffer.sv ***
// small receive buffer memory with registered read data
// assumes writer never writes when full and reader never reads when empty
`timescale 1ns/10ps
module rx_byte_buffer
    import host_port_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic wr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic rd_in,
    output logic [7:0] rd_data_out,
    output logic [BUF_AW:0] level_out
);
    logic [7:0] mem [BUF_DEPTH];
    logic [BUF_AW-1:0] wr_ptr;
    logic [BUF_AW-1:0] rd_ptr;

    always_ff @(posedge clk_in)
    begin
        if (wr_in)
        begin
            mem[wr_ptr] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level_out <= '0;
            rd_data_out <= 8'h00;
        end
        else
        begin
            if (wr_in)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (rd_in)
            begin
                rd_ptr <= rd_ptr + 1'b1;
                rd_data_out <= mem[rd_ptr];
            end
            case ({wr_in, rd_in})
                2'b10: level_out <= level_out + 1'b1;
                2'b01: level_out <= level_out - 1'b1;
                default: level_out <= level_out;
            endcase
        end
    end
endmodule : rx_byte_buffer

// *** rtl/printer_host_receive.sv ***
// host receive port: parallel handshake, serial receiver, flow control, address decode
// assumes host holds data stable around strobe; all inputs synchronous to clk_in
`timescale 1ns/10ps
// What this block does
// R1: latch eight parallel data lines just after host strobe falls
// R2: raise busy once a parallel byte is captured
// R3: after byte handling, pulse acknowledge then drop busy
// R4: each byte goes to the receive buffer or straight to command processing; a serial byte arriving while the buffer is full is dropped
// R5: serial bits are assembled into bytes, then treated like parallel bytes
// R6: soft protocol sends resume char near empty, pause char when full
// R7: hardware protocol asserts ready line while data can be accepted
// R8: an open ready-sense line disables flow control tied to it
// R9: 000000-0000BF on-chip I/O, 0000C0-0000FF external I/O
// R10: 000100-5FFFFF is work RAM, read and write
// R11: 600000-DFFFFF is read-only program region
// R12: E00000-EFFFFF reads program memory, writes extended RAM
// R13: F00000-FFFFFF reads program memory, writes receive/download RAM
// R14: bus serves 4M firmware ROM, two 16M ROMs, 128K x 16 RAM
// R15: host keeps data stable and waits for busy low and acknowledge
module printer_host_receive
    import host_port_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] host_data_in,
    input wire logic host_strobe_n_in,
    input wire logic serial_rx_in,
    input wire logic ready_sense_line_in,
    input wire logic ready_sense_open_in,
    input wire logic [1:0] protocol_in,
    input wire logic direct_mode_in,
    input wire logic cmd_ready_in,
    input wire logic buf_pop_in,
    input wire logic [23:0] bus_addr_in,
    input wire logic bus_rd_in,
    input wire logic bus_wr_in,
    output logic host_busy_out,
    output logic host_ack_n_out,
    output logic serial_tx_out,
    output logic dtr_out,
    output rx_byte_t cmd_byte_out,
    output logic [7:0] buf_data_out,
    output logic [BUF_AW:0] buf_level_out,
    output mem_sel_t mem_sel_out,
    output logic [3:0] rom_cs_out,
    output logic ram_cs_out
);
    typedef enum { P_IDLE, P_HOLD, P_ACK } par_state_t;
    typedef enum { S_IDLE, S_START, S_DATA, S_STOP } ser_state_t;

    par_state_t par_state;
    ser_state_t ser_state;
    logic strobe_d;
    logic [7:0] par_hold;
    logic [15:0] ack_cnt;
    logic par_done;
    logic [15:0] ser_cnt;
    logic [2:0] ser_bit;
    logic [7:0] ser_shift;
    logic ser_valid;
    logic [7:0] ser_byte;
    logic buf_wr;
    logic [7:0] buf_wdata;
    logic buf_full;
    logic near_empty;
    logic paused;
    logic tx_busy;
    logic [9:0] tx_shift;
    logic [3:0] tx_bits;
    logic [15:0] tx_cnt;
    mem_sel_t next_sel;

    assign buf_full = (buf_level_out == BUF_DEPTH[BUF_AW:0]);
    assign near_empty = (buf_level_out <= NEAR_EMPTY_LEVEL);

    // parallel handshake
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            par_state <= P_IDLE;
            strobe_d <= 1'b1;
            par_hold <= 8'h00;
            host_busy_out <= 1'b0;
            host_ack_n_out <= 1'b1;
            ack_cnt <= '0;
        end
        else
        begin
            strobe_d <= host_strobe_n_in;
            case (par_state)
                P_IDLE:
                begin
                    // strobes while busy are ignored, host must wait // see R15
                    if (strobe_d && !host_strobe_n_in)
                    begin
                        par_hold <= host_data_in; // see R1
                        host_busy_out <= 1'b1; // see R2
                        par_state <= P_HOLD;
                    end
                end
                P_HOLD:
                begin
                    if (par_done)
                    begin
                        host_ack_n_out <= 1'b0; // see R3
                        ack_cnt <= '0;
                        par_state <= P_ACK;
                    end
                end
                P_ACK:
                begin
                    ack_cnt <= ack_cnt + 1'b1;
                    if (ack_cnt == 16'(ACK_CYCLES - 1))
                    begin
                        host_ack_n_out <= 1'b1;
                        host_busy_out <= 1'b0; // see R3
                        par_state <= P_IDLE;
                    end
                end
                default: par_state <= P_IDLE;
            endcase
        end
    end

    // serial receiver, 8N1
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ser_state <= S_IDLE;
            ser_cnt <= '0;
            ser_bit <= '0;
            ser_shift <= 8'h00;
            ser_valid <= 1'b0;
            ser_byte <= 8'h00;
        end
        else
        begin
            if (ser_valid && par_state != P_HOLD)
            begin
                ser_valid <= 1'b0;
            end
            ser_cnt <= ser_cnt + 1'b1;
            case (ser_state)
                S_IDLE:
                begin
                    ser_cnt <= '0;
                    if (!serial_rx_in)
                    begin
                        ser_state <= S_START;
                    end
                end
                S_START:
                begin
                    if (ser_cnt == 16'(HALF_BIT_CYCLES))
                    begin
                        ser_cnt <= '0;
                        ser_bit <= '0;
                        ser_state <= serial_rx_in ? S_IDLE : S_DATA;
                    end
                end
                S_DATA:
                begin
                    if (ser_cnt == 16'(BIT_CYCLES - 1))
                    begin
                        ser_cnt <= '0;
                        ser_shift <= {serial_rx_in, ser_shift[7:1]}; // see R5
                        ser_bit <= ser_bit + 1'b1;
                        if (ser_bit == 3'h7)
                        begin
                            ser_state <= S_STOP;
                        end
                    end
                end
                S_STOP:
                begin
                    if (ser_cnt == 16'(BIT_CYCLES - 1))
                    begin
                        ser_state <= S_IDLE;
                        if (serial_rx_in)
                        begin
                            ser_byte <= ser_shift; // see R5
                            ser_valid <= 1'b1;
                        end
                    end
                end
                default: ser_state <= S_IDLE;
            endcase
        end
    end

    // byte routing: parallel has priority; serial waits while parallel is in P_HOLD
    always_comb
    begin
        par_done = 1'b0;
        buf_wr = 1'b0;
        buf_wdata = par_hold;
        if (par_state == P_HOLD)
        begin
            if (direct_mode_in)
            begin
                par_done = cmd_ready_in; // see R4
            end
            else
            begin
                par_done = !buf_full;
                buf_wr = !buf_full; // see R4
            end
        end
        else if (ser_valid && !direct_mode_in && !buf_full)
        begin
            buf_wr = 1'b1; // see R4
            buf_wdata = ser_byte;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cmd_byte_out <= '0;
        end
        else
        begin
            cmd_byte_out.valid <= 1'b0;
            if (par_state == P_HOLD && par_done)
            begin
                cmd_byte_out <= '{valid: 1'b1, to_buffer: !direct_mode_in, data: par_hold};
            end
            else if (ser_valid && par_state != P_HOLD)
            begin
                // a full buffer drops serial bytes: flow control should prevent it
                cmd_byte_out <= '{valid: 1'b1, to_buffer: !direct_mode_in, data: ser_byte};
            end
        end
    end

    rx_byte_buffer u_buf (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .wr_in(buf_wr),
        .wr_data_in(buf_wdata),
        .rd_in(buf_pop_in && buf_level_out != '0),
        .rd_data_out(buf_data_out),
        .level_out(buf_level_out)
    );

    // flow control
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            dtr_out <= 1'b0;
        end
        else
        begin
            // open sense line: no handshake, hold ready asserted // see R8
            if (ready_sense_open_in)
            begin
                dtr_out <= 1'b1;
            end
            else if (protocol_in == PROTO_DTR)
            begin
                dtr_out <= !buf_full && ready_sense_line_in; // see R7
            end
            else
            begin
                dtr_out <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            paused <= 1'b0;
            tx_busy <= 1'b0;
            tx_shift <= 10'h3FF;
            tx_bits <= '0;
            tx_cnt <= '0;
            serial_tx_out <= 1'b1;
        end
        else
        begin
            if (tx_busy)
            begin
                tx_cnt <= tx_cnt + 1'b1;
                if (tx_cnt == 16'(BIT_CYCLES - 1))
                begin
                    tx_cnt <= '0;
                    serial_tx_out <= tx_shift[0];
                    tx_shift <= {1'b1, tx_shift[9:1]};
                    tx_bits <= tx_bits + 1'b1;
                    // hold busy through a whole stop bit so back-to-back chars keep framing
                    if (tx_bits == 4'hA)
                    begin
                        tx_busy <= 1'b0;
                    end
                end
            end
            else if (protocol_in == PROTO_SOFT && !ready_sense_open_in)
            begin
                // hysteresis between full and near-empty avoids char storms
                if (!paused && buf_full)
                begin
                    paused <= 1'b1;
                    tx_shift <= {1'b1, CHAR_PAUSE, 1'b0}; // see R6
                    tx_busy <= 1'b1;
                    tx_bits <= '0;
                    tx_cnt <= 16'(BIT_CYCLES - 1);
                end
                else if (paused && near_empty)
                begin
                    paused <= 1'b0;
                    tx_shift <= {1'b1, CHAR_RESUME, 1'b0}; // see R6
                    tx_busy <= 1'b1;
                    tx_bits <= '0;
                    tx_cnt <= 16'(BIT_CYCLES - 1);
                end
            end
        end
    end

    // address decode
    always_comb
    begin
        next_sel = SEL_NONE;
        if (bus_rd_in || bus_wr_in)
        begin
            if (bus_addr_in <= IO_ONCHIP_END)
            begin
                next_sel = SEL_IO_ONCHIP; // see R9
            end
            else if (bus_addr_in <= IO_EXT_END)
            begin
                next_sel = SEL_IO_EXT; // see R9
            end
            else if (bus_addr_in <= WORK_RAM_END)
            begin
                next_sel = SEL_WORK_RAM; // see R10
            end
            else if (bus_addr_in <= PROG_END)
            begin
                next_sel = bus_rd_in ? SEL_PROG_ROM : SEL_NONE; // see R11
            end
            else if (bus_addr_in <= EXT_REGION_END)
            begin
                next_sel = bus_rd_in ? SEL_PROG_ROM : SEL_EXT_RAM; // see R12
            end
            else
            begin
                next_sel = bus_rd_in ? SEL_PROG_ROM : SEL_RX_BUF_RAM; // see R13
            end
        end
    end

    // chip selects: firmware, ROM A, ROM B (character option), spare
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mem_sel_out <= SEL_NONE;
            rom_cs_out <= 4'h0;
            ram_cs_out <= 1'b0;
        end
        else
        begin
            mem_sel_out <= next_sel;
            rom_cs_out <= 4'h0;
            if (next_sel == SEL_PROG_ROM)
            begin
                rom_cs_out[bus_addr_in[23:22] - 2'h1] <= 1'b1; // see R14
            end
            ram_cs_out <= (next_sel == SEL_WORK_RAM) || (next_sel == SEL_EXT_RAM)
                || (next_sel == SEL_RX_BUF_RAM); // see R14
        end
    end
endmodule : printer_host_receive

// *** sim/printer_host_receive_chk.sv ***
// assertions on the host receive port
// bound to printer_host_receive, one clock domain
`timescale 1ns/10ps
module printer_host_receive_chk
    import host_port_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] host_data_in,
    input wire logic host_strobe_n_in,
    input wire logic serial_rx_in,
    input wire logic ready_sense_line_in,
    input wire logic ready_sense_open_in,
    input wire logic [1:0] protocol_in,
    input wire logic direct_mode_in,
    input wire logic cmd_ready_in,
    input wire logic buf_pop_in,
    input wire logic [23:0] bus_addr_in,
    input wire logic bus_rd_in,
    input wire logic bus_wr_in,
    input wire logic host_busy_out,
    input wire logic host_ack_n_out,
    input wire logic serial_tx_out,
    input wire logic dtr_out,
    input wire rx_byte_t cmd_byte_out,
    input wire logic [7:0] buf_data_out,
    input wire logic [BUF_AW:0] buf_level_out,
    input wire mem_sel_t mem_sel_out,
    input wire logic [3:0] rom_cs_out,
    input wire logic ram_cs_out
);
    // counts low cycles of ack, too wide a count needs no checking
    logic [7:0] ack_len;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            ack_len <= 8'h00;
        else if (host_ack_n_out)
            ack_len <= 8'h00;
        else
            ack_len <= ack_len + 8'h01;
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    sequence s_take;
        $fell(host_strobe_n_in) && !host_busy_out;
    endsequence
    sequence s_direct_ack;
        s_take ##2 ($fell(host_ack_n_out) && direct_mode_in);
    endsequence
    property p_take;
        s_take |=> host_busy_out;
    endproperty
    a_take: assert property (p_take) else $error("busy not raised");
    property p_latch;
        s_direct_ack |-> cmd_byte_out.valid && !cmd_byte_out.to_buffer && cmd_byte_out.data == $past(host_data_in, 2);
    endproperty
    a_latch: assert property (p_latch) else $error("captured byte wrong");
    property p_ack_len;
        $rose(host_ack_n_out) |-> ack_len == 8'(ACK_CYCLES);
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack width wrong");
    property p_ack_end;
        $rose(host_ack_n_out) |-> !host_busy_out;
    endproperty
    a_ack_end: assert property (p_ack_end) else $error("busy held after ack");
    property p_busy_drop;
        $fell(host_busy_out) |-> $rose(host_ack_n_out);
    endproperty
    a_busy_drop: assert property (p_busy_drop) else $error("busy dropped without ack");
    property p_ack_busy;
        !host_ack_n_out |-> host_busy_out;
    endproperty
    a_ack_busy: assert property (p_ack_busy) else $error("ack outside busy");
    property p_pulse;
        cmd_byte_out.valid |=> !cmd_byte_out.valid;
    endproperty
    a_pulse: assert property (p_pulse) else $error("byte valid too long");
    property p_dtr_off;
        protocol_in == PROTO_DTR && !ready_sense_open_in && !ready_sense_line_in |=> !dtr_out;
    endproperty
    a_dtr_off: assert property (p_dtr_off) else $error("ready while host not ready");
    property p_dtr_open;
        protocol_in == PROTO_DTR && ready_sense_open_in |=> dtr_out;
    endproperty
    a_dtr_open: assert property (p_dtr_open) else $error("open sense not ignored");
    property p_dec_io;
        bus_rd_in && bus_addr_in <= IO_ONCHIP_END |=> mem_sel_out == SEL_IO_ONCHIP;
    endproperty
    a_dec_io: assert property (p_dec_io) else $error("on-chip io decode");
    property p_dec_ro;
        bus_wr_in && !bus_rd_in && bus_addr_in > WORK_RAM_END && bus_addr_in <= PROG_END |=> mem_sel_out == SEL_NONE;
    endproperty
    a_dec_ro: assert property (p_dec_ro) else $error("write to program region");
    property p_dec_buf;
        bus_wr_in && !bus_rd_in && bus_addr_in > EXT_REGION_END |=> mem_sel_out == SEL_RX_BUF_RAM && ram_cs_out;
    endproperty
    a_dec_buf: assert property (p_dec_buf) else $error("buffer ram decode");
endmodule : printer_host_receive_chk

// *** sim/host_model.sv ***
// host side: parallel strobe and data, serial line toward the port
// assumes busy and ack from the port; drives on falling clock edges
`timescale 1ns/10ps
module host_model
    import host_port_pkg::*;
(
    input wire logic clk_in,
    input wire logic busy_in,
    input wire logic ack_n_in,
    output logic [7:0] data_out,
    output logic strobe_n_out,
    output logic rx_out
);
    initial
    begin
        data_out = 8'h00;
        strobe_n_out = 1'b1;
        rx_out = 1'b1;
    end
    // waits for busy low, holds data over strobe, waits out ack
    task automatic send_par(input logic [7:0] b, input int hold);
        int n;
        n = 0;
        @(negedge clk_in);
        while (busy_in !== 1'b0 && n < 3000)
        begin
            @(negedge clk_in);
            n++;
        end
        data_out = b;
        strobe_n_out = 1'b0;
        repeat (hold) @(negedge clk_in);
        strobe_n_out = 1'b1;
        // released data no longer shows the byte
        data_out = ~b;
        while (ack_n_in !== 1'b0 && n < 3000)
        begin
            @(negedge clk_in);
            n++;
        end
        while (ack_n_in !== 1'b1 && n < 3000)
        begin
            @(negedge clk_in);
            n++;
        end
    endtask : send_par
    task automatic send_ser(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rx_out = f[i];
            repeat (BIT_CYCLES) @(negedge clk_in);
        end
    endtask : send_ser
endmodule : host_model

// *** sim/tb_printer_host_receive.sv ***
// bench for the host receive port, host model on the far side
// assumes 20 MHz clock and package baud and ack figures
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_printer_host_receive
    import host_port_pkg::*;
;
    logic clk_in = 1'b0, rst_n_in = 1'b0, sense = 1'b1, open = 1'b0, direct = 1'b0;
    logic cmd_ready = 1'b1, pop = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [1:0] proto = PROTO_NONE;
    logic [23:0] addr = 24'h000000;
    logic [7:0] hdata;
    logic strobe_n, rx, busy, ack_n, tx, dtr, ram_cs;
    logic [7:0] bdata;
    logic [BUF_AW:0] level;
    logic [3:0] rom_cs;
    rx_byte_t cmd;
    mem_sel_t sel;
    int bad_count = 0;
    int n_tests = 0;
    printer_host_receive dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .host_data_in(hdata),
        .host_strobe_n_in(strobe_n), .serial_rx_in(rx), .ready_sense_line_in(sense),
        .ready_sense_open_in(open), .protocol_in(proto), .direct_mode_in(direct), .cmd_ready_in(cmd_ready),
        .buf_pop_in(pop), .bus_addr_in(addr), .bus_rd_in(rd), .bus_wr_in(wr), .host_busy_out(busy),
        .host_ack_n_out(ack_n), .serial_tx_out(tx), .dtr_out(dtr), .cmd_byte_out(cmd), .buf_data_out(bdata),
        .buf_level_out(level), .mem_sel_out(sel), .rom_cs_out(rom_cs), .ram_cs_out(ram_cs));
    host_model host (.clk_in(clk_in), .busy_in(busy), .ack_n_in(ack_n), .data_out(hdata),
        .strobe_n_out(strobe_n), .rx_out(rx));
    initial
    begin
        forever #25 clk_in = ~clk_in;
    end
    function automatic logic [7:0] pat(input int i);
        return 8'(i * 7 + 3);
    endfunction : pat
    task automatic end_of_test;
        if (bad_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    task automatic wait_cmd(input int lim);
        int n;
        n = 0;
        while (cmd.valid !== 1'b1 && n < lim)
        begin
            @(negedge clk_in);
            n++;
        end
        if (n >= lim)
            bad_count++;
    endtask : wait_cmd
    // one handshake in direct mode, command side stalls for stall cycles, ack timed
    task automatic par_direct(input logic [7:0] b, input int hold, input int stall);
        int n;
        cmd_ready = (stall == 0);
        fork
            host.send_par(b, hold);
            begin
                repeat (stall) @(negedge clk_in);
                if (stall > 0)
                    `CHK("ack during stall", 1'b1, ack_n)
                cmd_ready = 1'b1;
                wait_cmd(50);
                `CHK("cmd data", b, cmd.data)
                `CHK("to buffer", 1'b0, cmd.to_buffer)
                `CHK("busy", 1'b1, busy)
                n = 0;
                while (ack_n === 1'b0 && n < 500)
                begin
                    @(negedge clk_in);
                    n++;
                end
                `CHK("ack width", ACK_CYCLES, n)
                `CHK("busy end", 1'b0, busy)
            end
        join
    endtask : par_direct
    // decodes one character from the transmit line
    task automatic rx_char(input logic [7:0] e);
        logic [7:0] c;
        int n;
        n = 0;
        while (tx !== 1'b0 && n < 25000)
        begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 25000)
            bad_count++;
        repeat (HALF_BIT_CYCLES) @(negedge clk_in);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CYCLES) @(negedge clk_in);
            c[i] = tx;
        end
        repeat (BIT_CYCLES) @(negedge clk_in);
        `CHK("flow char", e, c)
        `CHK("stop bit", 1'b1, tx)
    endtask : rx_char
    task automatic t_fill_soft;
        proto = PROTO_SOFT;
        direct = 1'b0;
        for (int i = 0; i < BUF_DEPTH; i++)
            host.send_par(pat(i), 2);
        `CHK("level full", 7'h40, level)
        rx_char(CHAR_PAUSE);
        for (int i = 0; i < 48; i++)
        begin
            pop = 1'b1;
            @(negedge clk_in);
            pop = 1'b0;
            @(negedge clk_in);
            `CHK("buf data", pat(i), bdata)
        end
        `CHK("level", NEAR_EMPTY_LEVEL, level)
        rx_char(CHAR_RESUME);
    endtask : t_fill_soft
    task automatic t_dtr;
        proto = PROTO_DTR;
        repeat (2) @(negedge clk_in);
        `CHK("dtr ready", 1'b1, dtr)
        sense = 1'b0;
        repeat (2) @(negedge clk_in);
        `CHK("dtr host off", 1'b0, dtr)
        open = 1'b1;
        repeat (2) @(negedge clk_in);
        `CHK("dtr open", 1'b1, dtr)
    endtask : t_dtr
    task automatic t_serial;
        proto = PROTO_NONE;
        direct = 1'b1;
        fork
            host.send_ser(8'hA5);
            begin
                wait_cmd(25000);
                `CHK("serial byte", 8'hA5, cmd.data)
            end
        join
    endtask : t_serial
    task automatic dec(input logic [23:0] a, input logic r, input mem_sel_t e, input logic [3:0] rc);
        addr = a;
        rd = r;
        wr = ~r;
        @(negedge clk_in);
        `CHK("sel", e, sel)
        `CHK("rom cs", rc, rom_cs)
        `CHK("ram cs", e inside {SEL_WORK_RAM, SEL_EXT_RAM, SEL_RX_BUF_RAM}, ram_cs)
        rd = 1'b0;
        wr = 1'b0;
        @(negedge clk_in);
    endtask : dec
    task automatic t_decode;
        dec(24'h0000BF, 1'b1, SEL_IO_ONCHIP, 4'h0);
        dec(24'h0000C0, 1'b0, SEL_IO_EXT, 4'h0);
        dec(24'h0000FF, 1'b1, SEL_IO_EXT, 4'h0);
        dec(24'h000100, 1'b0, SEL_WORK_RAM, 4'h0);
        dec(24'h5FFFFF, 1'b1, SEL_WORK_RAM, 4'h0);
        dec(24'h600000, 1'b1, SEL_PROG_ROM, 4'h1);
        dec(24'h800000, 1'b1, SEL_PROG_ROM, 4'h2);
        dec(24'hDFFFFF, 1'b0, SEL_NONE, 4'h0);
        dec(24'hE00000, 1'b1, SEL_PROG_ROM, 4'h4);
        dec(24'hEFFFFF, 1'b0, SEL_EXT_RAM, 4'h0);
        dec(24'hF00000, 1'b1, SEL_PROG_ROM, 4'h4);
        dec(24'hFFFFFF, 1'b0, SEL_RX_BUF_RAM, 4'h0);
    endtask : t_decode
    initial
    begin
        repeat (6) @(negedge clk_in);
        rst_n_in = 1'b1;
        @(negedge clk_in);
        `CHK("busy rst", 1'b0, busy)
        `CHK("tx idle", 1'b1, tx)
        direct = 1'b1;
        par_direct(8'h5A, 3, 0);
        par_direct(8'hC3, 1, 10);
        t_fill_soft();
        t_dtr();
        t_serial();
        t_decode();
        end_of_test();
    end
    // whole run is near 68000 cycles; limit at 90000
    initial
    begin
        #4_500_000;
        bad_count++;
        end_of_test();
    end
endmodule : tb_printer_host_receive
bind printer_host_receive printer_host_receive_chk u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .host_data_in(host_data_in), .host_strobe_n_in(host_strobe_n_in), .serial_rx_in(serial_rx_in),
    .ready_sense_line_in(ready_sense_line_in), .ready_sense_open_in(ready_sense_open_in),
    .protocol_in(protocol_in), .direct_mode_in(direct_mode_in), .cmd_ready_in(cmd_ready_in),
    .buf_pop_in(buf_pop_in), .bus_addr_in(bus_addr_in), .bus_rd_in(bus_rd_in), .bus_wr_in(bus_wr_in),
    .host_busy_out(host_busy_out), .host_ack_n_out(host_ack_n_out), .serial_tx_out(serial_tx_out),
    .dtr_out(dtr_out), .cmd_byte_out(cmd_byte_out), .buf_data_out(buf_data_out),
    .buf_level_out(buf_level_out), .mem_sel_out(mem_sel_out), .rom_cs_out(rom_cs_out), .ram_cs_out(ram_cs_out));
